// >>> rtl/cisx_pkg.sv
// package: shared types and constants for the instruction subset executor
package cisx_pkg;

   // ---------------------------------------------------------------
   // flag byte layout and reset values
   // ---------------------------------------------------------------
   localparam int FLAG_C = 7; // carry / borrow
   localparam int FLAG_Z = 6; // zero
   localparam int FLAG_S = 5; // sign
   localparam int FLAG_V = 4; // signed overflow
   localparam int FLAG_D = 3; // decimal-adjust
   localparam int FLAG_H = 2; // half carry
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ---------------------------------------------------------------
   // opcode fields
   // ---------------------------------------------------------------
   localparam logic [3:0] HI_ADD = 4'h0; // plain add
   localparam logic [3:0] HI_ADC = 4'h1; // add with carry
   localparam logic [3:0] HI_AND = 4'h5; // bitwise and
   localparam logic [3:0] HI_CMP = 4'hA; // compare_op
   localparam logic [3:0] LO_LOOP = 4'hA; // decrement_branch_nonzero_op
   localparam logic [7:0] OP_CALL_DIR = 8'hD6; // call, direct_address_mode
   localparam logic [7:0] OP_CALL_IRR = 8'hD4; // call through register pair
   localparam logic [7:0] OP_BDN_R = 8'h00; // byte_decrement_op, direct
   localparam logic [7:0] OP_BDN_I = 8'h01; // byte_decrement_op, indirect_register_mode
   localparam logic [7:0] OP_WDN_R = 8'h80; // word_decrement_op, register_pair_mode
   localparam logic [7:0] OP_WDN_I = 8'h81; // word_decrement_op, indirect

   // lower nibble addressing pairs for two-operand operations
   localparam logic [3:0] AM_W_W = 4'h2; // working to working
   localparam logic [3:0] AM_W_IW = 4'h3; // working to indirect working
   localparam logic [3:0] AM_R_R = 4'h4; // register to register
   localparam logic [3:0] AM_R_IND = 4'h5; // register to indirect
   localparam logic [3:0] AM_R_IM = 4'h6; // register with immediate
   localparam logic [3:0] AM_IND_IM = 4'h7; // indirect with immediate

   // instruction lengths in bytes, used to advance program_counter
   localparam logic [15:0] LEN_2 = 16'h0002;
   localparam logic [15:0] LEN_3 = 16'h0003;
   localparam logic [15:0] SP_STEP = 16'h0002; // a pushed program_counter takes two bytes
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [15:0] WORD_ONE = 16'h0001;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_AND} cisx_alu_op_t;

   typedef enum logic [2:0] {
      K_NONE, K_ARITH, K_AND, K_CMP, K_BDN, K_WDN, K_LOOP, K_CALL
   } cisx_kind_t;

   // one instruction from the fetch path, with its operand bytes
   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [7:0] op1;
      logic [7:0] op2;
   } cisx_instr_t;

   // one word written to the stack
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [15:0] data;
   } cisx_push_t;

   // alu result with flags
   typedef struct packed {
      logic [7:0] result;
      logic c;
      logic z;
      logic s;
      logic v;
      logic h;
   } cisx_alu_res_t;

endpackage

// >>> rtl/cisx_alu.sv
// module: 8-bit adder/subtractor/and unit with flag outputs
`timescale 1ns/1ns
`default_nettype none

module cisx_alu (
   // operation and operands
   input wire cisx_pkg::cisx_alu_op_t op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   // result and flags
   output cisx_pkg::cisx_alu_res_t res
);

   // ---------------------------------------------------------------
   // datapath
   // ---------------------------------------------------------------
   logic [7:0] b_eff; // operand b, inverted for subtraction
   logic c_in_eff; // carry into bit 0
   logic [8:0] sum; // full sum with carry out
   logic [4:0] low_sum; // low nibble sum, gives the half carry

   // subtraction is a + ~b + 1, so one adder serves all arithmetic
   always_comb begin
      b_eff = (op == cisx_pkg::ALU_SUB) ? ~b : b;
      c_in_eff = (op == cisx_pkg::ALU_SUB) ? 1'b1 : ((op == cisx_pkg::ALU_ADC) ? cin : 1'b0);
      sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_in_eff};
      low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_in_eff};
      res.result = (op == cisx_pkg::ALU_AND) ? (a & b) : sum[7:0];
      // borrow is the inverse of carry out when subtracting
      res.c = (op == cisx_pkg::ALU_SUB) ? ~sum[8] : sum[8];
      res.z = (res.result == 8'h00);
      res.s = res.result[7];
      // signed overflow: operands agree in sign, result differs
      res.v = (op == cisx_pkg::ALU_AND) ? 1'b0 : ((a[7] == b_eff[7]) && (sum[7] != a[7]));
      res.h = low_sum[4];
   end

endmodule // cisx_alu
`default_nettype wire

// >>> rtl/cisx_core.sv
// module: executor for add, add with carry, and, call, compare, decrements and loop branch
`timescale 1ns/1ns
`default_nettype none

module cisx_core (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // instruction from the fetch path, executed in one cycle
   input wire cisx_pkg::cisx_instr_t instr,
   input wire logic [3:0] working_bank,
   // register file read-back
   input wire logic [7:0] peek_addr,
   output logic [7:0] peek_data,
   // core state
   output logic [7:0] flags,
   output logic [15:0] program_counter,
   output logic [15:0] stack_pointer,
   // stack writes and completion
   output cisx_pkg::cisx_push_t push,
   output logic done,
   output logic unknown_op
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [255:0][7:0] regs; // register file, one byte per index
      logic [7:0] flags;
      logic [15:0] pc;
      logic [15:0] sp;
      cisx_pkg::cisx_push_t push;
      logic [7:0] peek;
      logic done;
      logic unknown;
   } cisx_state_t;

   cisx_state_t st; // registered state
   cisx_state_t next_st; // next state

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   cisx_pkg::cisx_kind_t kind; // class of the current instruction
   cisx_pkg::cisx_alu_op_t alu_op; // alu operation
   logic [7:0] dst_addr; // destination register index
   logic [7:0] src_val; // source operand value
   logic [7:0] pair_addr; // even index of a register pair
   logic [15:0] len; // instruction length in bytes
   cisx_pkg::cisx_alu_res_t alu_res; // alu output
   logic [3:0] hi; // upper opcode nibble
   logic [3:0] lo; // lower opcode nibble

   // maps a working register number into the current bank
   function automatic logic [7:0] wreg(input logic [3:0] bank, input logic [3:0] n);
      wreg = {bank, n};
   endfunction

   // operand selection; indirect modes read the register file twice
   always_comb begin
      hi = instr.opcode[7:4];
      lo = instr.opcode[3:0];
      kind = cisx_pkg::K_NONE;
      alu_op = cisx_pkg::ALU_ADD;
      dst_addr = 8'h00;
      src_val = 8'h00;
      pair_addr = 8'h00;
      len = cisx_pkg::LEN_2;
      if ((lo >= cisx_pkg::AM_W_W) && (lo <= cisx_pkg::AM_IND_IM) &&
          ((hi == cisx_pkg::HI_ADD) || (hi == cisx_pkg::HI_ADC) ||
           (hi == cisx_pkg::HI_AND) || (hi == cisx_pkg::HI_CMP))) begin
         // addressing pair from the lower nibble
         unique case (lo)
            cisx_pkg::AM_W_W: begin
               dst_addr = wreg(working_bank, instr.op1[7:4]);
               src_val = st.regs[wreg(working_bank, instr.op1[3:0])];
            end
            cisx_pkg::AM_W_IW: begin
               dst_addr = wreg(working_bank, instr.op1[7:4]);
               src_val = st.regs[st.regs[wreg(working_bank, instr.op1[3:0])]];
            end
            cisx_pkg::AM_R_R: begin
               dst_addr = instr.op2;
               src_val = st.regs[instr.op1];
               len = cisx_pkg::LEN_3;
            end
            cisx_pkg::AM_R_IND: begin
               dst_addr = instr.op2;
               src_val = st.regs[st.regs[instr.op1]];
               len = cisx_pkg::LEN_3;
            end
            cisx_pkg::AM_R_IM: begin
               dst_addr = instr.op1;
               src_val = instr.op2;
               len = cisx_pkg::LEN_3;
            end
            default: begin
               dst_addr = st.regs[instr.op1];
               src_val = instr.op2;
               len = cisx_pkg::LEN_3;
            end
         endcase
         // operation from the upper nibble
         if (hi == cisx_pkg::HI_ADC) begin
            kind = cisx_pkg::K_ARITH;
            alu_op = cisx_pkg::ALU_ADC;
         end else if (hi == cisx_pkg::HI_ADD) begin
            kind = cisx_pkg::K_ARITH;
            alu_op = cisx_pkg::ALU_ADD;
         end else if (hi == cisx_pkg::HI_AND) begin
            kind = cisx_pkg::K_AND;
            alu_op = cisx_pkg::ALU_AND;
         end else begin
            kind = cisx_pkg::K_CMP;
            alu_op = cisx_pkg::ALU_SUB;
         end
      end else if (lo == cisx_pkg::LO_LOOP) begin
         // working register named by the upper nibble
         kind = cisx_pkg::K_LOOP;
         dst_addr = wreg(working_bank, hi);
         src_val = cisx_pkg::BYTE_ONE;
         alu_op = cisx_pkg::ALU_SUB;
      end else if ((instr.opcode == cisx_pkg::OP_BDN_R) ||
                   (instr.opcode == cisx_pkg::OP_BDN_I)) begin
         kind = cisx_pkg::K_BDN;
         dst_addr = (instr.opcode == cisx_pkg::OP_BDN_R) ? instr.op1 : st.regs[instr.op1];
         src_val = cisx_pkg::BYTE_ONE;
         alu_op = cisx_pkg::ALU_SUB;
      end else if ((instr.opcode == cisx_pkg::OP_WDN_R) ||
                   (instr.opcode == cisx_pkg::OP_WDN_I)) begin
         kind = cisx_pkg::K_WDN;
         pair_addr = (instr.opcode == cisx_pkg::OP_WDN_R) ? instr.op1 : st.regs[instr.op1];
         pair_addr[0] = 1'b0;
      end else if (instr.opcode == cisx_pkg::OP_CALL_DIR) begin
         kind = cisx_pkg::K_CALL;
         len = cisx_pkg::LEN_3;
      end else if (instr.opcode == cisx_pkg::OP_CALL_IRR) begin
         kind = cisx_pkg::K_CALL;
         pair_addr = {instr.op1[7:1], 1'b0};
      end
   end

   // shared arithmetic unit
   cisx_alu u_alu (
      .op(alu_op),
      .a(st.regs[dst_addr]),
      .b(src_val),
      .cin(st.flags[cisx_pkg::FLAG_C]),
      .res(alu_res)
   );

   // ---------------------------------------------------------------
   // execute
   // ---------------------------------------------------------------
   logic [15:0] word_old; // register pair before the decrement
   logic [15:0] word_new; // register pair after the decrement
   logic [15:0] target; // call destination
   logic [15:0] pc_next_instr; // address of the following instruction

   // everything retires in the cycle the instruction is presented
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.unknown = 1'b0;
      next_st.push.valid = 1'b0;
      next_st.peek = st.regs[peek_addr];
      word_old = {st.regs[pair_addr], st.regs[pair_addr + 8'h01]};
      word_new = word_old - cisx_pkg::WORD_ONE;
      target = (instr.opcode == cisx_pkg::OP_CALL_DIR) ? {instr.op1, instr.op2} : word_old;
      pc_next_instr = st.pc + len;
      if (instr.valid) begin
         next_st.done = (kind != cisx_pkg::K_NONE);
         next_st.unknown = (kind == cisx_pkg::K_NONE);
         if (kind != cisx_pkg::K_NONE) begin
            next_st.pc = pc_next_instr;
         end
         unique case (kind)
            cisx_pkg::K_ARITH: begin
               next_st.regs[dst_addr] = alu_res.result;
               next_st.flags[cisx_pkg::FLAG_C] = alu_res.c;
               next_st.flags[cisx_pkg::FLAG_Z] = alu_res.z;
               next_st.flags[cisx_pkg::FLAG_S] = alu_res.s;
               next_st.flags[cisx_pkg::FLAG_V] = alu_res.v;
               next_st.flags[cisx_pkg::FLAG_H] = alu_res.h;
               next_st.flags[cisx_pkg::FLAG_D] = 1'b0;
            end
            cisx_pkg::K_AND: begin
               // carry, decimal-adjust and half carry are left alone
               next_st.regs[dst_addr] = alu_res.result;
               next_st.flags[cisx_pkg::FLAG_Z] = alu_res.z;
               next_st.flags[cisx_pkg::FLAG_S] = alu_res.s;
               next_st.flags[cisx_pkg::FLAG_V] = 1'b0;
            end
            cisx_pkg::K_CMP: begin
               // result discarded, only flags move
               next_st.flags[cisx_pkg::FLAG_C] = alu_res.c;
               next_st.flags[cisx_pkg::FLAG_Z] = alu_res.z;
               next_st.flags[cisx_pkg::FLAG_S] = alu_res.s;
               next_st.flags[cisx_pkg::FLAG_V] = alu_res.v;
            end
            cisx_pkg::K_BDN: begin
               // borrow from the alu is dropped so carry holds
               next_st.regs[dst_addr] = alu_res.result;
               next_st.flags[cisx_pkg::FLAG_Z] = alu_res.z;
               next_st.flags[cisx_pkg::FLAG_S] = alu_res.s;
               next_st.flags[cisx_pkg::FLAG_V] = alu_res.v;
            end
            cisx_pkg::K_WDN: begin
               // high byte at the even index, low byte at the odd one
               next_st.regs[pair_addr] = word_new[15:8];
               next_st.regs[pair_addr + 8'h01] = word_new[7:0];
               next_st.flags[cisx_pkg::FLAG_Z] = (word_new == 16'h0000);
               next_st.flags[cisx_pkg::FLAG_S] = word_new[15];
               next_st.flags[cisx_pkg::FLAG_V] = (word_old == 16'h8000);
            end
            cisx_pkg::K_LOOP: begin
               // displacement counts from the following instruction
               next_st.regs[dst_addr] = alu_res.result;
               if (!alu_res.z) begin
                  next_st.pc = pc_next_instr + {{8{instr.op1[7]}}, instr.op1};
               end
            end
            cisx_pkg::K_CALL: begin
               next_st.sp = st.sp - cisx_pkg::SP_STEP;
               next_st.push.valid = 1'b1;
               next_st.push.addr = st.sp - cisx_pkg::SP_STEP;
               next_st.push.data = pc_next_instr;
               next_st.pc = target;
            end
            default: begin
               // unknown opcode: no state changes, flagged for one cycle
               next_st.pc = st.pc;
            end
         endcase
      end
   end

   // single register stage for all state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st.regs <= '0;
         st.flags <= cisx_pkg::FLAGS_RESET;
         st.pc <= cisx_pkg::PC_RESET;
         st.sp <= cisx_pkg::SP_RESET;
         st.push <= '0;
         st.peek <= cisx_pkg::REG_RESET;
         st.done <= 1'b0;
         st.unknown <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all straight from flops
   // ---------------------------------------------------------------
   assign peek_data = st.peek;
   assign flags = st.flags;
   assign program_counter = st.pc;
   assign stack_pointer = st.sp;
   assign push = st.push;
   assign done = st.done;
   assign unknown_op = st.unknown;

endmodule // cisx_core
`default_nettype wire

// >>> bench/cisx_checker.sv
// checker: concurrent assertions on the ports of the subset executor
`timescale 1ns/1ns
`default_nettype none

module cisx_checker (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // instruction side
   input wire cisx_pkg::cisx_instr_t instr,
   input wire logic [3:0] working_bank,
   input wire logic [7:0] peek_addr,
   // observed state
   input wire logic [7:0] peek_data,
   input wire logic [7:0] flags,
   input wire logic [15:0] program_counter,
   input wire logic [15:0] stack_pointer,
   input wire cisx_pkg::cisx_push_t push,
   input wire logic done,
   input wire logic unknown_op
);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   localparam int C = cisx_pkg::FLAG_C; // short flag indices
   localparam int D = cisx_pkg::FLAG_D;
   localparam int H = cisx_pkg::FLAG_H;
   wire logic [3:0] hi = instr.opcode[7:4]; // operation nibble
   wire logic [7:0] op = instr.opcode; // whole opcode
   // lower nibble 2 to 7 under any upper nibble, calls included, so lower nibble A stays with the branch
   wire logic two = instr.valid && op[3:0] >= 4'h2 && op[3:0] <= 4'h7;
   wire logic [15:0] pc = program_counter; // short alias

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   chk_add_dclear: assert property (two && (hi == 4'h0 || hi == 4'h1) |=> done && !flags[D])
      else $error("add did not clear decimal flag");
   chk_and_keeps: assert property (two && hi == 4'h5 |=> !flags[cisx_pkg::FLAG_V]
      && $stable(flags[C]) && $stable(flags[D]) && $stable(flags[H]))
      else $error("and changed kept flags");
   chk_call_push: assert property (instr.valid && op == 8'hD6 |=> push.valid
      && stack_pointer == $past(stack_pointer) - 16'h0002 && push.addr == stack_pointer
      && push.data == $past(pc) + 16'h0003 && pc == {$past(instr.op1), $past(instr.op2)})
      else $error("direct call push wrong");
   chk_call_flags: assert property (instr.valid && (op == 8'hD6 || op == 8'hD4) |=>
      $stable(flags) && push.valid)
      else $error("call touched flags");
   chk_cmp_keeps: assert property (two && hi == 4'hA |=> done && $stable(flags[D])
      && $stable(flags[H]))
      else $error("compare changed kept flags");
   chk_byte_down_carry: assert property (instr.valid && (op == 8'h00 || op == 8'h01) |=>
      $stable(flags[C]) && pc == $past(pc) + 16'h0002)
      else $error("byte decrement carry or length wrong");
   chk_word_down_carry: assert property (instr.valid && (op == 8'h80 || op == 8'h81) |=>
      $stable(flags[C]) && pc == $past(pc) + 16'h0002)
      else $error("word decrement carry or length wrong");
   chk_loop_target: assert property (instr.valid && op[3:0] == 4'hA |=> $stable(flags)
      && (pc == $past(pc) + 16'h0002
      || pc == $past(pc) + 16'h0002 + {{8{$past(instr.op1[7])}}, $past(instr.op1)}))
      else $error("branch target or flags wrong");
   chk_mode_len: assert property (two && (hi == 4'h0 || hi == 4'h1 || hi == 4'h5
      || hi == 4'hA) |=> pc == $past(pc) + ($past(op[3:0]) < 4'h4 ? 16'h0002 : 16'h0003))
      else $error("two-operand length wrong");
endmodule // cisx_checker

bind cisx_core cisx_checker cisx_checker_i (.clk(clk), .reset_n(reset_n), .instr(instr),
   .working_bank(working_bank), .peek_addr(peek_addr), .peek_data(peek_data), .flags(flags),
   .program_counter(program_counter), .stack_pointer(stack_pointer), .push(push),
   .done(done), .unknown_op(unknown_op));

`default_nettype wire

// >>> bench/tb.sv
// testbench: directed scenarios for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none

module tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk; // 100 MHz
   logic reset_n; // async, active low
   cisx_pkg::cisx_instr_t instr; // one instruction per cycle
   logic [3:0] working_bank; // bank 1 maps r0..rF to 0x10..0x1F
   logic [7:0] peek_addr;
   logic [7:0] peek_data;
   logic [7:0] flags;
   logic [15:0] program_counter;
   logic [15:0] stack_pointer;
   cisx_pkg::cisx_push_t push;
   logic done;
   logic unknown_op;
   int miscompares;
   int comparisons;

   cisx_core cisx_core_i (.clk(clk), .reset_n(reset_n), .instr(instr),
      .working_bank(working_bank), .peek_addr(peek_addr), .peek_data(peek_data),
      .flags(flags), .program_counter(program_counter), .stack_pointer(stack_pointer),
      .push(push), .done(done), .unknown_op(unknown_op));

   always #5 clk = ~clk; // half period

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   // one comparison; x on the design side never matches
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   // one instruction, held for a single edge; answer lands one cycle later
   task automatic ex(input logic [7:0] op, a, b, input logic [15:0] npc,
                     input logic [7:0] f, input logic d);
      @(posedge clk);
      instr <= {1'b1, op, a, b};
      @(posedge clk);
      instr <= '0;
      #1;
      chk("done", d, done);
      chk("unknown_op", !d, unknown_op);
      chk("program_counter", npc, program_counter);
      chk("flags", f, flags);
   endtask

   // register read-back has one cycle of latency
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      peek_addr <= a;
      @(posedge clk);
      #1;
      chk("peek_data", e, peek_data);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_add;
      ex(8'h06, 8'h10, 8'h0F, 16'h0003, 8'h00, 1'b1);
      ex(8'h06, 8'h10, 8'h01, 16'h0006, 8'h04, 1'b1);
      rd(8'h10, 8'h10);
   endtask

   task automatic t_adc;
      // wrap to zero leaves carry set for the next add
      ex(8'h06, 8'h10, 8'hF0, 16'h0009, 8'hC0, 1'b1);
      ex(8'h16, 8'h11, 8'h7F, 16'h000C, 8'h34, 1'b1);
      rd(8'h11, 8'h80);
   endtask

   task automatic t_and;
      ex(8'h56, 8'h11, 8'hC0, 16'h000F, 8'h24, 1'b1);
      rd(8'h11, 8'h80);
   endtask

   task automatic t_cmp;
      ex(8'hA6, 8'h11, 8'h01, 16'h0012, 8'h14, 1'b1);
      ex(8'hA6, 8'h11, 8'h81, 16'h0015, 8'hA4, 1'b1);
      rd(8'h11, 8'h80);
   endtask

   task automatic t_byte_down;
      ex(8'h00, 8'h11, 8'h00, 16'h0017, 8'h94, 1'b1);
      rd(8'h11, 8'h7F);
      ex(8'h01, 8'h10, 8'h00, 16'h0019, 8'hA4, 1'b1);
      rd(8'h00, 8'hFF);
   endtask

   task automatic t_word_down;
      ex(8'h80, 8'h12, 8'h00, 16'h001B, 8'hA4, 1'b1);
      rd(8'h12, 8'hFF);
      rd(8'h13, 8'hFF);
      ex(8'h81, 8'h11, 8'h00, 16'h001D, 8'hA4, 1'b1);
      rd(8'h7F, 8'hFF);
   endtask

   task automatic t_loop;
      ex(8'h06, 8'h14, 8'h01, 16'h0020, 8'h00, 1'b1);
      ex(8'h3A, 8'h7F, 8'h00, 16'h00A1, 8'h00, 1'b1);
      ex(8'h3A, 8'h80, 8'h00, 16'h0023, 8'h00, 1'b1);
      ex(8'h4A, 8'h80, 8'h00, 16'h0025, 8'h00, 1'b1);
      rd(8'h13, 8'hFD);
      rd(8'h14, 8'h00);
   endtask

   task automatic t_modes;
      ex(8'h02, 8'h43, 8'h00, 16'h0027, 8'h20, 1'b1);
      rd(8'h14, 8'hFD);
      ex(8'h04, 8'h13, 8'h15, 16'h002A, 8'h20, 1'b1);
      rd(8'h15, 8'hFD);
   endtask

   task automatic t_call;
      ex(8'hD6, 8'h12, 8'h34, 16'h1234, 8'h20, 1'b1);
      chk("push.valid", 16'h0001, push.valid);
      chk("push.addr", 16'hFFFE, push.addr);
      chk("push.data", 16'h002D, push.data);
      ex(8'hD4, 8'h12, 8'h00, 16'hFFFD, 8'h20, 1'b1);
      chk("stack_pointer", 16'hFFFC, stack_pointer);
      chk("push.data", 16'h1236, push.data);
   endtask

   task automatic t_unknown;
      // an opcode outside the subset must leave the program counter alone
      ex(8'hFF, 8'h00, 8'h00, 16'hFFFD, 8'h20, 1'b0);
      chk("stack_pointer", 16'hFFFC, stack_pointer);
   endtask

   task automatic t_indirect;
      // modes 3, 5 and 7 reach an operand through a register holding its index
      ex(8'h13, 8'h31, 8'h00, 16'hFFFF, 8'hA4, 1'b1);
      rd(8'h13, 8'hFC);
      ex(8'h55, 8'h14, 8'h15, 16'h0002, 8'hC4, 1'b1);
      rd(8'h15, 8'h00);
      ex(8'h07, 8'h11, 8'h02, 16'h0005, 8'h84, 1'b1);
      rd(8'h7F, 8'h01);
   endtask

   // ---------------------------------------------------------------
   // verdict
   // ---------------------------------------------------------------
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // main sequence: reset, reset values, then the scenarios in state order
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      instr = '0;
      working_bank = 4'h1;
      peek_addr = 8'h00;
      miscompares = 0;
      comparisons = 0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      chk("program_counter", 16'h0000, program_counter);
      chk("stack_pointer", 16'h0000, stack_pointer);
      chk("flags", 16'h0000, flags);
      t_add;
      t_adc;
      t_and;
      t_cmp;
      t_byte_down;
      t_word_down;
      t_loop;
      t_modes;
      t_call;
      t_unknown;
      t_indirect;
      summarize;
   end
endmodule // tb

`default_nettype wire
